// ### hw/trace_pkg.sv
// Purpose: shared constants for the trace sequencer and trigger block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes: pattern selector codes 0..7 pick a pattern set, the rest are any/never
package trace_pkg;
	localparam int N_TERMS = 8;
	localparam int N_PATS = 8;
	localparam int TERM_W = 3;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int STAT_W = 4;
	localparam int CNT_W = 20;
	localparam int OCC_W = 8;
	localparam int MEM_DEPTH = 64;
	localparam int PTR_W = 6;
	localparam int ENTRY_W = CNT_W + STAT_W + DATA_W + ADDR_W;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets (byte addresses); array groups hold one word per index
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_TRACE_IDX = 8'h08;
	localparam logic [7:0] OFS_TRACE_LO = 8'h0C;
	localparam logic [7:0] OFS_TRACE_HI = 8'h10;
	localparam logic [7:0] OFS_PAT_ADDR = 8'h40;
	localparam logic [7:0] OFS_PAT_DATA = 8'h60;
	localparam logic [7:0] OFS_PAT_STAT = 8'h80;
	localparam logic [7:0] OFS_TERM = 8'hA0;

	////////////////////////////////////////////////////////////////////////////////
	// control word fields
	localparam int CTRL_START = 0;
	localparam int CTRL_SEQ_RESET = 1;
	localparam int CTRL_TRIG_LSB = 4;
	localparam int CTRL_TIME = 8;
	localparam int CTRL_CENTER = 9;
	localparam int CTRL_POS_LSB = 16;
	localparam logic [31:0] CTRL_RST = 32'h0000_0010;

	// term word fields
	localparam int TERM_PSEL_LSB = 0;
	localparam int TERM_PTGT_LSB = 4;
	localparam int TERM_CNT_LSB = 8;
	localparam int TERM_SSEL_LSB = 16;
	localparam int TERM_STGT_LSB = 20;
	localparam int TERM_STO_LSB = 24;
	localparam int TERM_STOPAT_LSB = 26;

	// pattern data word: value low, care mask high; status word likewise
	localparam int PAT_CARE_LSB = 16;
	localparam int STAT_CARE_LSB = 4;

	localparam logic [3:0] SEL_ANY = 4'h8;
	localparam logic [3:0] SEL_NEVER = 4'hF;
	localparam logic [1:0] STO_ALL = 2'h0;
	localparam logic [1:0] STO_NONE = 2'h1;
	localparam logic [1:0] STO_PAT = 2'h2;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'b0001,
		ST_PRE = 4'b0010,
		ST_POST = 4'b0100,
		ST_DONE = 4'b1000
	} run_state_t;

	// power-up term: any -> next term (last term never -> term 0), secondary never, store all, count 1
	function automatic logic [31:0] term_default(input int idx);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[TERM_PSEL_LSB +: 4] = (idx == N_TERMS - 1) ? SEL_NEVER : SEL_ANY;
		w[TERM_PTGT_LSB +: TERM_W] = 3'((idx + 1) % N_TERMS);
		w[TERM_CNT_LSB +: OCC_W] = 8'h01;
		w[TERM_SSEL_LSB +: 4] = SEL_NEVER;
		w[TERM_STO_LSB +: 2] = STO_ALL;
		return w;
	endfunction : term_default
endpackage : trace_pkg

// ### hw/trace_mem.sv
// Purpose: trace memory, one write port and one registered read port
// Assumes: single clock, read data valid one cycle after the address
// Notes: no reset on the array; contents are undefined until written
module trace_mem
	import trace_pkg::*;
(
	input wire logic clk,
	input wire logic we,
	input wire logic [PTR_W-1:0] waddr,
	input wire logic [ENTRY_W-1:0] wdata,
	input wire logic [PTR_W-1:0] raddr,
	output logic [ENTRY_W-1:0] rdata
);
	logic [ENTRY_W-1:0] mem [MEM_DEPTH];

	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : trace_mem

// ### hw/trace_sequencer_trigger.sv
// Purpose: eight-term trace sequencer with trigger, storage qualifiers and trace memory
// Assumes: observed bus pins are asynchronous and sampled on the rising processor clock
// Notes on behaviour
// - primary target taken when primary pattern comes first, else secondary target.
// - trigger asserted when sequencer first enters the selected trigger term after start.
// - term with both branches never holds until sequencer reset.
// - any one of the eight terms may be chosen as trigger term.
// - each term has its own storage qualifier: all, none or pattern.
// - a state that causes a branch is always stored.
// - primary branch fires only after its pattern matched count times in term.
// - trigger position programmable as states below top of trace.
// - trigger position may be set to the trace centre.
// - in time mode each stored state carries elapsed time since previous one.
// - pattern matches only when address, data with don't-cares and status agree.
// - enable term storing none, disable term storing all, gives windowed trace.
// - state matching both branches never takes the secondary; primary fires once its count is reached.
// - occurrence counts only on primary branches; secondary fires on first match.
// - eight terms, each with primary, secondary, targets, count and qualifier.
// - defaults: any/never branches, store all, second term is trigger term.
module trace_sequencer_trigger
	import trace_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic proc_clk_pin,
	input wire logic [ADDR_W-1:0] bus_addr_pin,
	input wire logic [DATA_W-1:0] bus_data_pin,
	input wire logic [STAT_W-1:0] bus_stat_pin,
	output logic trigger,
	output logic trace_done
);
	function automatic logic in_group(input logic [7:0] a, input logic [7:0] base);
		return a[7:5] == base[7:5];
	endfunction : in_group

	function automatic logic sel_hit(input logic [3:0] sel, input logic [N_PATS-1:0] hits);
		if (sel == SEL_ANY)
			return 1'b1;
		else if (sel[3])
			return 1'b0;
		else
			return hits[sel[2:0]];
	endfunction : sel_hit

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; only stage two and later are read by logic
	logic [2:0] pclk_s;
	logic [ADDR_W-1:0] addr_s1, addr_s2;
	logic [DATA_W-1:0] data_s1, data_s2;
	logic [STAT_W-1:0] stat_s1, stat_s2;

	always_ff @(posedge clk)
	begin
		pclk_s <= {pclk_s[1:0], proc_clk_pin};
		addr_s1 <= bus_addr_pin;
		addr_s2 <= addr_s1;
		data_s1 <= bus_data_pin;
		data_s2 <= data_s1;
		stat_s1 <= bus_stat_pin;
		stat_s2 <= stat_s1;
	end

	// one captured state per rising processor clock
	logic sample;
	assign sample = pclk_s[1] & ~pclk_s[2];

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [31:0] pat_addr_r [N_PATS], pat_addr_nxt [N_PATS];
	logic [31:0] pat_data_r [N_PATS], pat_data_nxt [N_PATS];
	logic [31:0] pat_stat_r [N_PATS], pat_stat_nxt [N_PATS];
	logic [31:0] term_r [N_TERMS], term_nxt [N_TERMS];
	logic [PTR_W-1:0] trace_idx_r, trace_idx_nxt;
	logic wr_ok;
	logic [2:0] widx;

	assign wr_ok = avs_write;
	assign widx = avs_address[4:2];

	always_comb
	begin
		ctrl_nxt = ctrl_r;
		pat_addr_nxt = pat_addr_r;
		pat_data_nxt = pat_data_r;
		pat_stat_nxt = pat_stat_r;
		term_nxt = term_r;
		trace_idx_nxt = trace_idx_r;
		// start and sequencer reset stand for one cycle after the write that sets them
		ctrl_nxt[CTRL_START] = 1'b0;
		ctrl_nxt[CTRL_SEQ_RESET] = 1'b0;
		if (wr_ok)
		begin
			if (avs_address == OFS_CTRL)
				ctrl_nxt = avs_writedata;
			else if (avs_address == OFS_TRACE_IDX)
				trace_idx_nxt = avs_writedata[PTR_W-1:0];
			else if (in_group(avs_address, OFS_PAT_ADDR))
				pat_addr_nxt[widx] = avs_writedata;
			else if (in_group(avs_address, OFS_PAT_DATA))
				pat_data_nxt[widx] = avs_writedata;
			else if (in_group(avs_address, OFS_PAT_STAT))
				pat_stat_nxt[widx] = avs_writedata;
			else if (in_group(avs_address, OFS_TERM))
				term_nxt[widx] = avs_writedata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctrl_r <= CTRL_RST;
			trace_idx_r <= '0;
			for (int i = 0; i < N_PATS; i++)
			begin
				pat_addr_r[i] <= 32'h0000_0000;
				pat_data_r[i] <= 32'h0000_0000;
				pat_stat_r[i] <= 32'h0000_0000;
			end
			for (int i = 0; i < N_TERMS; i++)
			begin
				term_r[i] <= term_default(i);
			end
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			trace_idx_r <= trace_idx_nxt;
			pat_addr_r <= pat_addr_nxt;
			pat_data_r <= pat_data_nxt;
			pat_stat_r <= pat_stat_nxt;
			term_r <= term_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pattern matching: each set is independent; selectors pick one set, any or never
	logic [N_PATS-1:0] pat_hit;

	for (genvar g = 0; g < N_PATS; g++)
	begin : g_pat
		logic a_ok, d_ok, s_ok;
		assign a_ok = addr_s2 == pat_addr_r[g][ADDR_W-1:0];
		assign d_ok = ((data_s2 ^ pat_data_r[g][DATA_W-1:0])
			& pat_data_r[g][PAT_CARE_LSB +: DATA_W]) == '0;
		assign s_ok = ((stat_s2 ^ pat_stat_r[g][STAT_W-1:0])
			& pat_stat_r[g][STAT_CARE_LSB +: STAT_W]) == '0;
		assign pat_hit[g] = a_ok & d_ok & s_ok;
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer, storage and trigger position
	logic start_cmd, seq_rst_cmd, time_mode;
	logic [TERM_W-1:0] trig_term;
	logic [PTR_W-1:0] pos_below, post_len;
	run_state_t st_r, st_nxt;
	logic [TERM_W-1:0] term_cur_r, term_cur_nxt;
	logic [OCC_W-1:0] occ_r, occ_nxt;
	logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt, post_r, post_nxt, trig_idx_r, trig_idx_nxt;
	logic [CNT_W-1:0] gap_r, gap_nxt;
	logic trig_r, trig_nxt, trigd_r, trigd_nxt;
	logic [31:0] tw;
	logic [OCC_W-1:0] cnt_lim;
	logic running, p_hit, s_hit, p_fire, s_fire, branch, qual, store;
	logic [TERM_W-1:0] target;
	logic trig_evt;
	logic [ENTRY_W-1:0] mem_q;

	assign start_cmd = ctrl_r[CTRL_START];
	assign seq_rst_cmd = ctrl_r[CTRL_SEQ_RESET];
	assign time_mode = ctrl_r[CTRL_TIME];
	assign trig_term = ctrl_r[CTRL_TRIG_LSB +: TERM_W];
	// centre keeps 32 states before the trigger entry and 31 after it
	assign pos_below = ctrl_r[CTRL_CENTER] ? PTR_W'(MEM_DEPTH / 2)
		: ctrl_r[CTRL_POS_LSB +: PTR_W];
	assign post_len = PTR_W'(MEM_DEPTH - 1) - pos_below;

	assign tw = term_r[term_cur_r];
	assign cnt_lim = (tw[TERM_CNT_LSB +: OCC_W] == '0) ? 8'h01 : tw[TERM_CNT_LSB +: OCC_W];
	assign running = (st_r == ST_PRE) || (st_r == ST_POST);
	assign p_hit = sample & running & sel_hit(tw[TERM_PSEL_LSB +: 4], pat_hit);
	assign s_hit = sample & running & sel_hit(tw[TERM_SSEL_LSB +: 4], pat_hit);
	assign p_fire = p_hit & ({1'b0, occ_r} + 9'h001 >= {1'b0, cnt_lim});
	// a primary match, counted or not, shadows the secondary
	assign s_fire = s_hit & ~p_hit;
	assign branch = p_fire | s_fire;
	assign target = p_fire ? tw[TERM_PTGT_LSB +: TERM_W] : tw[TERM_STGT_LSB +: TERM_W];

	always_comb
	begin
		unique case (tw[TERM_STO_LSB +: 2])
			STO_ALL: qual = 1'b1;
			STO_NONE: qual = 1'b0;
			default: qual = sel_hit({1'b0, tw[TERM_STOPAT_LSB +: 3]}, pat_hit);
		endcase
	end

	// qualifier of the current term only, plus every branching state
	assign store = sample & running & (branch | qual);
	assign trig_evt = branch & (target == trig_term) & ~trigd_r;

	always_comb
	begin
		st_nxt = st_r;
		term_cur_nxt = term_cur_r;
		occ_nxt = occ_r;
		wr_ptr_nxt = wr_ptr_r;
		post_nxt = post_r;
		trig_idx_nxt = trig_idx_r;
		trigd_nxt = trigd_r;
		trig_nxt = 1'b0;
		gap_nxt = gap_r;
		// elapsed clock cycles in time mode, else captured states
		if ((time_mode || sample) && gap_r != '1)
			gap_nxt = gap_r + CNT_W'(1);
		if (branch)
		begin
			term_cur_nxt = target;
			occ_nxt = '0;
		end
		else if (p_hit)
		begin
			occ_nxt = occ_r + OCC_W'(1);
		end
		if (trig_evt)
		begin
			trig_nxt = 1'b1;
			trigd_nxt = 1'b1;
			trig_idx_nxt = wr_ptr_r;
			post_nxt = post_len;
		end
		if (store)
		begin
			wr_ptr_nxt = wr_ptr_r + PTR_W'(1);
			gap_nxt = time_mode ? CNT_W'(1) : '0;
		end
		unique case (st_r)
			ST_IDLE, ST_DONE:
			begin
			end
			ST_PRE:
			begin
				if (trig_evt)
					st_nxt = (post_len == '0) ? ST_DONE : ST_POST;
			end
			ST_POST:
			begin
				if (store)
				begin
					post_nxt = post_r - PTR_W'(1);
					if (post_r == PTR_W'(1))
						st_nxt = ST_DONE;
				end
			end
		endcase
		if (seq_rst_cmd || start_cmd)
		begin
			term_cur_nxt = '0;
			occ_nxt = '0;
		end
		if (start_cmd)
		begin
			st_nxt = ST_PRE;
			wr_ptr_nxt = '0;
			trigd_nxt = 1'b0;
			gap_nxt = '0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_r <= ST_IDLE;
			term_cur_r <= '0;
			occ_r <= '0;
			wr_ptr_r <= '0;
			post_r <= '0;
			trig_idx_r <= '0;
			trigd_r <= 1'b0;
			trig_r <= 1'b0;
			gap_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			term_cur_r <= term_cur_nxt;
			occ_r <= occ_nxt;
			wr_ptr_r <= wr_ptr_nxt;
			post_r <= post_nxt;
			trig_idx_r <= trig_idx_nxt;
			trigd_r <= trigd_nxt;
			trig_r <= trig_nxt;
			gap_r <= gap_nxt;
		end
	end

	assign trigger = trig_r;
	assign trace_done = (st_r == ST_DONE);

	trace_mem u_mem (
		.clk(clk),
		.we(store),
		.waddr(wr_ptr_r),
		.wdata({gap_r, stat_s2, data_s2, addr_s2}),
		.raddr(trace_idx_r),
		.rdata(mem_q)
	);

	////////////////////////////////////////////////////////////////////////////////
	// bus read side: one wait cycle so the registered mux settles
	logic rd_valid_r, rd_valid_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	always_comb
	begin
		rd_valid_nxt = avs_read & ~rd_valid_r;
		rdata_nxt = rdata_r;
		if (avs_read && !rd_valid_r)
		begin
			rdata_nxt = 32'h0000_0000;
			if (avs_address == OFS_CTRL)
				rdata_nxt = {ctrl_r[31:2], 2'h0}; // command bits read back as zero
			else if (avs_address == OFS_STATUS)
				rdata_nxt = {trig_idx_r, 7'h00, wr_ptr_r, 5'h00, term_cur_r, trigd_r, st_r};
			else if (avs_address == OFS_TRACE_IDX)
				rdata_nxt = {26'h0, trace_idx_r};
			else if (avs_address == OFS_TRACE_LO)
				rdata_nxt = mem_q[31:0];
			else if (avs_address == OFS_TRACE_HI)
				rdata_nxt = {4'h0, mem_q[ENTRY_W-1:32]};
			else if (in_group(avs_address, OFS_PAT_ADDR))
				rdata_nxt = pat_addr_r[avs_address[4:2]];
			else if (in_group(avs_address, OFS_PAT_DATA))
				rdata_nxt = pat_data_r[avs_address[4:2]];
			else if (in_group(avs_address, OFS_PAT_STAT))
				rdata_nxt = pat_stat_r[avs_address[4:2]];
			else if (in_group(avs_address, OFS_TERM))
				rdata_nxt = term_r[avs_address[4:2]];
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rd_valid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			rd_valid_r <= rd_valid_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign avs_waitrequest = avs_read & ~rd_valid_r;
	assign avs_readdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	a_primary_target: assert property (p_fire && !start_cmd && !seq_rst_cmd
		|=> term_cur_r == $past(tw[TERM_PTGT_LSB +: TERM_W]))
		else $error("primary branch went to wrong term");
	a_both_primary: assert property (p_hit && s_hit |-> !s_fire)
		else $error("secondary taken while primary matched");
	a_trigger_entry: assert property (trig_evt && !start_cmd && !seq_rst_cmd
		|=> trigger && term_cur_r == trig_term)
		else $error("trigger not raised on entry to trigger term");
	a_never_holds: assert property (tw[TERM_PSEL_LSB +: 4] == SEL_NEVER
		&& tw[TERM_SSEL_LSB +: 4] == SEL_NEVER && !start_cmd && !seq_rst_cmd
		|=> $stable(term_cur_r))
		else $error("sequencer left a never/never term");
	a_branch_stored: assert property (branch |-> store)
		else $error("branching state not stored");
	a_store_none: assert property (running && sample && !branch
		&& tw[TERM_STO_LSB +: 2] == STO_NONE |-> !store)
		else $error("state stored against none qualifier");
	a_count_reached: assert property (p_fire |-> occ_r == cnt_lim - OCC_W'(1))
		else $error("primary fired before count reached");
	a_post_done: assert property (st_r == ST_POST && store && post_r == PTR_W'(1)
		|=> trace_done ##1 trace_done)
		else $error("trace did not stop after post-trigger states");
	a_start_clears: assert property (start_cmd |=> term_cur_r == '0 && occ_r == '0
		&& st_r == ST_PRE)
		else $error("start did not return to term one");
	a_read_wait: assert property (avs_read && !rd_valid_r |=> !avs_waitrequest || !avs_read)
		else $error("read waited more than one cycle");

	c_trigger: cover property (trigger);
	c_done: cover property (st_r == ST_POST ##[1:200] trace_done);
	c_secondary: cover property (s_fire);
	c_counted: cover property (p_fire && cnt_lim > 8'h01);
endmodule : trace_sequencer_trigger

// ### tb/proc_bus_model.sv
// Purpose: observed processor bus, one captured state per processor clock
// Assumes: pins sampled by the block through two flops on the rising processor clock
// Notes: processor clock stands still low between states
module proc_bus_model
	import trace_pkg::*;
(
	input wire logic clk,
	output logic proc_clk_pin,
	output logic [ADDR_W-1:0] bus_addr_pin,
	output logic [DATA_W-1:0] bus_data_pin,
	output logic [STAT_W-1:0] bus_stat_pin
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		proc_clk_pin = 1'b0;
		bus_addr_pin = '0;
		bus_data_pin = '0;
		bus_stat_pin = '0;
	end

	// pins settle 3 cycles before the edge and hold 5 after, past the synchroniser
	task automatic send(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [STAT_W-1:0] s);
		@(posedge clk);
		bus_addr_pin <= a;
		bus_data_pin <= d;
		bus_stat_pin <= s;
		repeat (3) @(posedge clk);
		proc_clk_pin <= 1'b1;
		repeat (3) @(posedge clk);
		proc_clk_pin <= 1'b0;
		repeat (2) @(posedge clk);
		// hold time over: show the inverse so stale values never pass for valid
		bus_addr_pin <= ~a;
		bus_data_pin <= ~d;
		bus_stat_pin <= ~s;
		repeat (3) @(posedge clk);
	endtask : send
endmodule : proc_bus_model

// ### tb/test_trace_sequencer_trigger.sv
// Purpose: self-checking bench for the trace sequencer and trigger
// Assumes: register access over Avalon-MM with waitrequest
// Notes: one state takes 12 clock cycles on the observed bus
module test_trace_sequencer_trigger
	import trace_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [ADDR_W-1:0] A_ENTER = 20'h00448;
	localparam logic [ADDR_W-1:0] A_HIT = 20'h005FF;
	localparam logic [ADDR_W-1:0] A_EXIT = 20'h00490;
	localparam logic [ADDR_W-1:0] A_OTHER = 20'h00100;
	localparam logic [STAT_W-1:0] MEM_WR = 4'h2; // memory_write_status, arbitrary code
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic proc_clk_pin;
	logic [ADDR_W-1:0] bus_addr_pin;
	logic [DATA_W-1:0] bus_data_pin;
	logic [STAT_W-1:0] bus_stat_pin;
	logic trigger;
	logic trace_done;
	logic [31:0] rv;
	logic [31:0] cfg;
	int npost;
	int base;
	int trig_seen = 0;
	int cyc = 0;
	int n_errors = 0;
	int tests_run = 0;

	trace_sequencer_trigger i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.proc_clk_pin(proc_clk_pin), .bus_addr_pin(bus_addr_pin), .bus_data_pin(bus_data_pin),
		.bus_stat_pin(bus_stat_pin), .trigger(trigger), .trace_done(trace_done));

	proc_bus_model i_bus (.clk(clk), .proc_clk_pin(proc_clk_pin), .bus_addr_pin(bus_addr_pin),
		.bus_data_pin(bus_data_pin), .bus_stat_pin(bus_stat_pin));

	always #50 clk = ~clk;

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (trigger === 1'b1)
			trig_seen <= trig_seen + 1;
		if (cyc == 20000)
		begin
			n_errors = n_errors + 1;
			complete_run();
		end
	end

	////////////////////////////////////////
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// the request stands until the rising edge at which waitrequest is seen low;
	// values read right after the edge are those the edge sampled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		avs_write <= 1'b1;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
		begin
			@(posedge clk);
		end
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		avs_read <= 1'b1;
		avs_address <= a;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
		begin
			@(posedge clk);
		end
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : rd

	task automatic set_pat(input int i, input logic [19:0] a, input logic [15:0] dv,
		input logic [15:0] dc, input logic [3:0] sv, input logic [3:0] sc);
		wr(OFS_PAT_ADDR + 8'(4 * i), {12'h000, a});
		wr(OFS_PAT_DATA + 8'(4 * i), {dc, dv});
		wr(OFS_PAT_STAT + 8'(4 * i), {24'h000000, sc, sv});
	endtask : set_pat

	task automatic set_term(input int i, input logic [3:0] ps, input logic [2:0] pt,
		input logic [7:0] cnt, input logic [3:0] ss, input logic [2:0] st, input logic [1:0] sto);
		wr(OFS_TERM + 8'(4 * i), {6'h00, sto, 1'b0, st, ss, cnt, 1'b0, pt, ps});
	endtask : set_term

	task automatic seq_is(input logic [2:0] t, input int ntrig);
		rd(OFS_STATUS, rv);
		check("current term", 32'(rv[7:5]), 32'(t));
		check("trigger pulses", 32'(trig_seen - base), 32'(ntrig));
	endtask : seq_is

	////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rd(OFS_CTRL, rv);
		check("control reset", rv, 32'h0000_0010);
		for (int i = 0; i < N_TERMS; i++)
		begin
			rd(OFS_TERM + 8'(4 * i), rv);
			check("term reset", rv, (i == 7) ? 32'h000F_010F : (32'h000F_0108 | 32'((i + 1) << 4)));
		end
		wr(8'h30, 32'hFFFF_FFFF);
		rd(8'h30, rv);
		check("unmapped", rv, 32'h0);
		rd(OFS_STATUS, rv);
		check("idle state", 32'(rv[3:0]), 32'h1);
		$display("test registers done");

		// states below top of trace, then centre: 53 and 31 stores after the trigger
		for (int k = 0; k < 2; k++)
		begin
			cfg = (k == 1) ? 32'h0000_0210 : 32'h000A_0010;
			npost = (k == 1) ? 31 : 53;
			base = trig_seen;
			wr(OFS_CTRL, cfg | 32'h1);
			i_bus.send(A_OTHER, 16'h1234, 4'h0);
			check("default trigger", 32'(trig_seen - base), 32'h1);
			repeat (npost - 1) i_bus.send(A_OTHER, 16'h1234, 4'h0);
			check("done early", 32'(trace_done), 32'h0);
			i_bus.send(A_OTHER, 16'h1234, 4'h0);
			check("done", 32'(trace_done), 32'h1);
		end
		$display("test trigger position done");

		set_pat(0, A_ENTER, 16'h0000, 16'h0000, 4'h0, 4'h0);
		set_pat(1, A_HIT, 16'h0F70, 16'hFF00, MEM_WR, 4'hF);
		set_pat(2, A_EXIT, 16'h0000, 16'h0000, 4'h0, 4'h0);
		set_term(0, 4'h0, 3'd1, 8'h01, SEL_NEVER, 3'd0, STO_ALL);
		set_term(1, 4'h1, 3'd4, 8'h02, 4'h2, 3'd2, STO_ALL);
		set_term(4, SEL_NEVER, 3'd0, 8'h01, SEL_NEVER, 3'd0, STO_ALL);
		base = trig_seen;
		wr(OFS_CTRL, 32'h0000_0041);
		seq_is(3'd0, 0);
		i_bus.send(A_ENTER, 16'h0000, 4'h0);
		seq_is(3'd1, 0);
		i_bus.send(A_HIT, 16'h0F75, 4'h3);
		seq_is(3'd1, 0);
		i_bus.send(A_HIT, 16'h0E75, MEM_WR);
		seq_is(3'd1, 0);
		i_bus.send(A_HIT, 16'h0F75, MEM_WR);
		seq_is(3'd1, 0);
		i_bus.send(A_HIT, 16'h0F7A, MEM_WR);
		seq_is(3'd4, 1);
		i_bus.send(A_EXIT, 16'h0000, 4'h0);
		seq_is(3'd4, 1);
		check("trigger index", 32'(rv[31:26]), 32'd4);
		wr(OFS_TRACE_IDX, 32'd4);
		rd(OFS_TRACE_LO, rv);
		check("trigger entry low", rv, 32'hF7A0_05FF);
		rd(OFS_TRACE_HI, rv);
		check("trigger entry high", rv, 32'h0000_0020);
		base = trig_seen;
		wr(OFS_CTRL, 32'h0000_0041);
		i_bus.send(A_ENTER, 16'h0000, 4'h0);
		i_bus.send(A_EXIT, 16'h0000, 4'h0);
		seq_is(3'd2, 0);
		set_term(1, 4'h1, 3'd4, 8'h01, 4'h1, 3'd2, STO_ALL);
		base = trig_seen;
		wr(OFS_CTRL, 32'h0000_0041);
		i_bus.send(A_ENTER, 16'h0000, 4'h0);
		i_bus.send(A_HIT, 16'h0F7A, MEM_WR);
		seq_is(3'd4, 1);
		$display("test branching done");

		// window: enable term stores nothing, disable term stores all, time counted
		set_term(0, 4'h0, 3'd1, 8'h01, SEL_NEVER, 3'd0, STO_NONE);
		set_term(1, 4'h2, 3'd0, 8'h01, SEL_NEVER, 3'd0, STO_ALL);
		base = trig_seen;
		wr(OFS_CTRL, 32'h0000_0171);
		i_bus.send(A_OTHER, 16'h1234, 4'h0);
		i_bus.send(A_ENTER, 16'h0000, 4'h0);
		i_bus.send(A_OTHER, 16'h1234, 4'h0);
		i_bus.send(A_EXIT, 16'h0000, 4'h0);
		i_bus.send(A_OTHER, 16'h1234, 4'h0);
		seq_is(3'd0, 0);
		check("window stores", 32'(rv[18:13]), 32'd3);
		wr(OFS_TRACE_IDX, 32'd1);
		rd(OFS_TRACE_HI, rv);
		check("elapsed time", rv, 32'h0000_0C01);
		$display("test window done");
		complete_run();
	end
endmodule : test_trace_sequencer_trigger
